// >>> dec_regs.svh
// Constants for the display economy control block
// Operation
// RULE1 - Economy enabled: backlight off after thirty minutes without any key press.
// RULE2 - Any key press restores the backlight after an economy switch-off.
// RULE3 - Active alarm keeps the backlight lit, overriding economy and timeout.
// RULE4 - Power-on or hardware error flags also stop backlight switch-off.
// RULE5 - Economy setting: off, all but PV off, all off, or 10 percent.
// RULE6 - Backlight toggle accepted from assigned function key or contact input.
// RULE7 - Message contact input on replaces PV display with that scrolling message.
// RULE8 - Each stored message holds at most twenty alphanumeric characters.
// RULE9 - Exactly four message slots exist, no more.
// RULE10 - Several message requests: show highest, slot one first, slot four last.
// RULE11 - Auto-return on: menu reverts to operation display after five idle minutes.
// RULE12 - Refresh period: 1=100 ms, 2=200 ms, 3=500 ms, 4=1 s, 5=2 s.
// RULE13 - Guide scroll rate selectable from 1 slowest to 8 fastest.
// RULE14 - Mode key in menu or parameter display toggles guide display.
// RULE15 - Brightness 1 to 5; region trims signed from -4 to 4.
// RULE16 - After power-up the startup-screen setting picks the operation screen.
// RULE17 - Every key press restarts both inactivity timers from zero.
`ifndef DEC_REGS_SVH
`define DEC_REGS_SVH
`define DEC_CLK_HZ 50000000
`define DEC_MS_CYCLES (`DEC_CLK_HZ / 1000)
`define DEC_ECO_MIN 30
`define DEC_RET_MIN 5
`define DEC_MS_PER_MIN 60000
`define DEC_MSG_CHARS 20
`define DEC_MSG_SLOTS 4
`define DEC_DIM_PCT 8'h0a
`define DEC_FULL_PCT 8'h64
`define DEC_ECO_OFF 2'h0
`define DEC_ECO_KEEP_PV 2'h1
`define DEC_ECO_ALL_OFF 2'h2
`define DEC_ECO_DIM 2'h3
`define DEC_BRI_MIN 3'h1
`define DEC_BRI_MAX 3'h5
`define DEC_BRI_DEF 3'h3
`define DEC_TRIM_MIN (-4)
`define DEC_TRIM_MAX 4
`define DEC_SCROLL_MIN 4'h1
`define DEC_SCROLL_MAX 4'h8
`define DEC_SCROLL_BASE_MS 800
`define DEC_SCROLL_STEP_MS 100
`define DEC_PER_100 16'd100
`define DEC_PER_200 16'd200
`define DEC_PER_500 16'd500
`define DEC_PER_1S 16'd1000
`define DEC_PER_2S 16'd2000
`endif

// >>> dec_pkg.sv
// Types of the display economy control block
package dec_pkg;
    typedef enum logic [1:0] {
        DEC_SCR_OPER = 2'b01,
        DEC_SCR_MENU = 2'b10
    } dec_screen_t;
    typedef logic [7:0] dec_char_t;
    typedef logic signed [3:0] dec_trim_t;
endpackage

// >>> dec_tick_if.sv
// Millisecond tick carried between the divider and the controller
`timescale 1ns/1ns
interface dec_tick_if;
    logic ms_tick;
    modport src (output ms_tick);
    modport dst (input ms_tick);
endinterface // dec_tick_if

// >>> dec_idle_timer.sv
// Inactivity timer counted in milliseconds, restarted by key presses
`timescale 1ns/1ns
module dec_idle_timer #(
    parameter int LIMIT_MS = 1000
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control
    input wire logic ms_tick,
    input wire logic restart,
    input wire logic run,
    // Result
    output logic expired
);
    logic [31:0] count_r;

    // Restart on key and count while running
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_r <= 32'h0;
        end else if (restart || !run) begin
            count_r <= 32'h0;
        end else if (ms_tick && count_r < LIMIT_MS) begin
            count_r <= count_r + 32'h1;
        end
    end

    assign expired = run && (count_r >= LIMIT_MS);
endmodule // dec_idle_timer

// >>> dec_display_ctrl.sv
// Display economy, message overlay, guide and refresh control
`timescale 1ns/1ns
`include "dec_regs.svh"
module dec_display_ctrl #(
    parameter int MS_CYCLES = `DEC_MS_CYCLES,
    parameter int ECO_MS = `DEC_ECO_MIN * `DEC_MS_PER_MIN,
    parameter int RET_MS = `DEC_RET_MIN * `DEC_MS_PER_MIN
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Front panel pins
    input wire logic key_any_pin,
    input wire logic mode_key_pin,
    input wire logic fkey_bl_pin,
    input wire logic [3:0] msg_contact_pin,
    input wire logic bl_contact_pin,
    // Status flags from the controller
    input wire logic alarm_active,
    input wire logic power_on_error,
    input wire logic hw_error,
    input wire logic menu_request,
    // Settings
    input wire logic [1:0] economy_setting,
    input wire logic auto_return_enable,
    input wire logic [2:0] refresh_period_select,
    input wire logic [3:0] guide_scroll_rate,
    input wire logic guide_visible_init,
    input wire logic [2:0] overall_brightness,
    input wire dec_pkg::dec_trim_t pv_white_trim,
    input wire dec_pkg::dec_trim_t pv_red_trim,
    input wire dec_pkg::dec_trim_t setpoint_trim,
    input wire dec_pkg::dec_trim_t bargraph_trim,
    input wire dec_pkg::dec_trim_t status_led_trim,
    input wire logic [3:0] startup_screen,
    input wire logic bl_key_assigned,
    input wire logic bl_contact_assigned,
    // Message storage write port
    input wire logic msg_wr,
    input wire logic [1:0] msg_wr_slot,
    input wire logic [4:0] msg_wr_index,
    input wire dec_pkg::dec_char_t msg_wr_char,
    // LCD side
    output logic backlight_on,
    output logic pv_lit,
    output logic others_lit,
    output logic [7:0] light_percent,
    output logic [2:0] brightness_level,
    output dec_pkg::dec_trim_t pv_white_level,
    output dec_pkg::dec_trim_t pv_red_level,
    output dec_pkg::dec_trim_t setpoint_level,
    output dec_pkg::dec_trim_t bargraph_level,
    output dec_pkg::dec_trim_t status_led_level,
    output logic msg_active,
    output logic [1:0] msg_slot,
    output dec_pkg::dec_char_t msg_char,
    output logic [4:0] msg_pos,
    output logic in_menu,
    output logic guide_visible,
    output logic guide_step,
    output logic refresh_tick,
    output logic [3:0] home_screen
);
    import dec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [8:0] pin_meta_r;
    logic [8:0] pin_sync_r;
    logic [8:0] pin_prev_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta_r <= 9'h0;
            pin_sync_r <= 9'h0;
            pin_prev_r <= 9'h0;
        end else begin
            pin_meta_r <= {bl_contact_pin, msg_contact_pin, fkey_bl_pin, mode_key_pin, key_any_pin};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    logic key_press;
    logic mode_press;
    logic fkey_press;
    logic contact_edge;
    logic [3:0] msg_req;
    // Any key counts, including mode and function keys
    assign key_press = |(pin_sync_r[2:0] & ~pin_prev_r[2:0]);
    assign mode_press = pin_sync_r[1] & ~pin_prev_r[1];
    assign fkey_press = pin_sync_r[2] & ~pin_prev_r[2];
    assign contact_edge = pin_sync_r[7] & ~pin_prev_r[7];
    assign msg_req = pin_sync_r[6:3];

    ////////////////////////////////////////////////////////////////////////
    // Millisecond divider and idle timers
    dec_tick_if tick_bus ();
    logic [31:0] div_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_r <= 32'h0;
        end else if (div_r >= MS_CYCLES - 1) begin
            div_r <= 32'h0;
        end else begin
            div_r <= div_r + 32'h1;
        end
    end
    assign tick_bus.ms_tick = (div_r >= MS_CYCLES - 1);

    logic eco_enabled;
    logic eco_expired;
    logic ret_expired;
    logic screen_menu;
    assign eco_enabled = (economy_setting != `DEC_ECO_OFF);

    // RULE1 thirty-minute timer
    // RULE17 key restarts timers
    dec_idle_timer #(.LIMIT_MS(ECO_MS)) u_eco_timer (
        .clock(clock),
        .resetn(resetn),
        .ms_tick(tick_bus.ms_tick),
        .restart(key_press),
        .run(eco_enabled),
        .expired(eco_expired)
    );

    // RULE11 five-minute return timer
    dec_idle_timer #(.LIMIT_MS(RET_MS)) u_ret_timer (
        .clock(clock),
        .resetn(resetn),
        .ms_tick(tick_bus.ms_tick),
        .restart(key_press),
        .run(auto_return_enable && screen_menu),
        .expired(ret_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // Backlight economy
    logic eco_dark_r;
    logic bl_manual_off_r;
    logic keep_lit;
    // RULE3 alarm keeps light
    // RULE4 errors keep light
    assign keep_lit = alarm_active || power_on_error || hw_error;

    // RULE1 economy switch-off
    // RULE2 key restores light
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            eco_dark_r <= 1'b0;
        end else if (key_press || keep_lit || !eco_enabled) begin
            eco_dark_r <= 1'b0;
        end else if (eco_expired) begin
            eco_dark_r <= 1'b1;
        end
    end

    // RULE6 assigned source toggles
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bl_manual_off_r <= 1'b0;
        end else if ((fkey_press && bl_key_assigned) || (contact_edge && bl_contact_assigned)) begin
            bl_manual_off_r <= ~bl_manual_off_r;
        end else if (keep_lit) begin
            bl_manual_off_r <= 1'b0;
        end
    end

    // RULE5 economy setting decode
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            backlight_on <= 1'b1;
            pv_lit <= 1'b1;
            others_lit <= 1'b1;
            light_percent <= `DEC_FULL_PCT;
        end else if (bl_manual_off_r && !keep_lit) begin
            backlight_on <= 1'b0;
            pv_lit <= 1'b0;
            others_lit <= 1'b0;
            light_percent <= 8'h0;
        end else if (eco_dark_r) begin
            case (economy_setting)
                `DEC_ECO_KEEP_PV: begin
                    backlight_on <= 1'b1;
                    pv_lit <= 1'b1;
                    others_lit <= 1'b0;
                    light_percent <= `DEC_FULL_PCT;
                end
                `DEC_ECO_ALL_OFF: begin
                    backlight_on <= 1'b0;
                    pv_lit <= 1'b0;
                    others_lit <= 1'b0;
                    light_percent <= 8'h0;
                end
                `DEC_ECO_DIM: begin
                    backlight_on <= 1'b1;
                    pv_lit <= 1'b1;
                    others_lit <= 1'b1;
                    light_percent <= `DEC_DIM_PCT;
                end
                default: begin
                    backlight_on <= 1'b1;
                    pv_lit <= 1'b1;
                    others_lit <= 1'b1;
                    light_percent <= `DEC_FULL_PCT;
                end
            endcase
        end else begin
            backlight_on <= 1'b1;
            pv_lit <= 1'b1;
            others_lit <= 1'b1;
            light_percent <= `DEC_FULL_PCT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Brightness settings, clamped to their legal ranges
    function automatic dec_trim_t clamp_trim(input dec_trim_t v);
        if (v < dec_trim_t'(`DEC_TRIM_MIN)) begin
            return dec_trim_t'(`DEC_TRIM_MIN);
        end else if (v > dec_trim_t'(`DEC_TRIM_MAX)) begin
            return dec_trim_t'(`DEC_TRIM_MAX);
        end
        return v;
    endfunction

    // RULE15 brightness ranges
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            brightness_level <= `DEC_BRI_DEF;
            pv_white_level <= 4'h0;
            pv_red_level <= 4'h0;
            setpoint_level <= 4'h0;
            bargraph_level <= 4'h0;
            status_led_level <= 4'h0;
        end else begin
            if (overall_brightness < `DEC_BRI_MIN) begin
                brightness_level <= `DEC_BRI_MIN;
            end else if (overall_brightness > `DEC_BRI_MAX) begin
                brightness_level <= `DEC_BRI_MAX;
            end else begin
                brightness_level <= overall_brightness;
            end
            pv_white_level <= clamp_trim(pv_white_trim);
            pv_red_level <= clamp_trim(pv_red_trim);
            setpoint_level <= clamp_trim(setpoint_trim);
            bargraph_level <= clamp_trim(bargraph_trim);
            status_led_level <= clamp_trim(status_led_trim);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Screen state and guide display
    dec_screen_t screen_r;
    assign screen_menu = (screen_r == DEC_SCR_MENU);
    assign in_menu = screen_menu;

    // Menu opens on a rising request only, so a timed-out menu stays closed
    logic menu_req_prev_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            menu_req_prev_r <= 1'b0;
        end else begin
            menu_req_prev_r <= menu_request;
        end
    end

    // RULE11 auto-return to operation
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            screen_r <= DEC_SCR_OPER;
        end else begin
            case (screen_r)
                DEC_SCR_OPER: begin
                    if (menu_request && !menu_req_prev_r) begin
                        screen_r <= DEC_SCR_MENU;
                    end
                end
                DEC_SCR_MENU: begin
                    if (ret_expired || !menu_request) begin
                        screen_r <= DEC_SCR_OPER;
                    end
                end
                default: begin
                    screen_r <= DEC_SCR_OPER;
                end
            endcase
        end
    end

    // Setting is taken once after reset, then the mode key owns it
    logic guide_loaded_r;
    // RULE14 mode key toggles guide
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            guide_loaded_r <= 1'b0;
            guide_visible <= 1'b1;
        end else if (!guide_loaded_r) begin
            guide_loaded_r <= 1'b1;
            guide_visible <= guide_visible_init;
        end else if (mode_press && screen_menu) begin
            guide_visible <= ~guide_visible;
        end
    end

    // RULE16 startup screen latch
    logic home_loaded_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            home_loaded_r <= 1'b0;
            home_screen <= 4'h0;
        end else if (!home_loaded_r) begin
            home_loaded_r <= 1'b1;
            home_screen <= startup_screen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Guide scroll and refresh period
    logic [3:0] rate;
    logic [15:0] scroll_ms;
    logic [15:0] scroll_cnt_r;
    // RULE13 scroll rate 1 to 8
    always_comb begin
        rate = guide_scroll_rate;
        if (rate < `DEC_SCROLL_MIN) begin
            rate = `DEC_SCROLL_MIN;
        end else if (rate > `DEC_SCROLL_MAX) begin
            rate = `DEC_SCROLL_MAX;
        end
        scroll_ms = 16'(`DEC_SCROLL_BASE_MS + `DEC_SCROLL_STEP_MS - `DEC_SCROLL_STEP_MS * rate);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scroll_cnt_r <= 16'h0;
            guide_step <= 1'b0;
        end else if (tick_bus.ms_tick) begin
            guide_step <= (scroll_cnt_r + 16'h1 >= scroll_ms);
            scroll_cnt_r <= (scroll_cnt_r + 16'h1 >= scroll_ms) ? 16'h0 : scroll_cnt_r + 16'h1;
        end else begin
            guide_step <= 1'b0;
        end
    end

    logic [15:0] period_ms;
    logic [15:0] refresh_cnt_r;
    // RULE12 refresh period decode
    always_comb begin
        case (refresh_period_select)
            3'h1: period_ms = `DEC_PER_100;
            3'h2: period_ms = `DEC_PER_200;
            3'h3: period_ms = `DEC_PER_500;
            3'h4: period_ms = `DEC_PER_1S;
            3'h5: period_ms = `DEC_PER_2S;
            default: period_ms = `DEC_PER_500;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            refresh_cnt_r <= 16'h0;
            refresh_tick <= 1'b0;
        end else if (tick_bus.ms_tick) begin
            refresh_tick <= (refresh_cnt_r + 16'h1 >= period_ms);
            refresh_cnt_r <= (refresh_cnt_r + 16'h1 >= period_ms) ? 16'h0 : refresh_cnt_r + 16'h1;
        end else begin
            refresh_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Message storage and overlay
    // RULE8 twenty characters
    // RULE9 four slots only
    dec_char_t msg_mem [`DEC_MSG_SLOTS][`DEC_MSG_CHARS];
    always_ff @(posedge clock) begin
        if (msg_wr && msg_wr_index < `DEC_MSG_CHARS) begin
            msg_mem[msg_wr_slot][msg_wr_index] <= msg_wr_char;
        end
    end

    // RULE10 slot one wins
    logic [1:0] win_slot;
    always_comb begin
        if (msg_req[0]) begin
            win_slot = 2'h0;
        end else if (msg_req[1]) begin
            win_slot = 2'h1;
        end else if (msg_req[2]) begin
            win_slot = 2'h2;
        end else begin
            win_slot = 2'h3;
        end
    end

    // RULE7 contact shows message
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            msg_active <= 1'b0;
            msg_slot <= 2'h0;
            msg_pos <= 5'h0;
        end else begin
            msg_active <= |msg_req;
            msg_slot <= win_slot;
            if (!(|msg_req) || win_slot != msg_slot) begin
                msg_pos <= 5'h0;
            end else if (guide_step) begin
                msg_pos <= (msg_pos == 5'(`DEC_MSG_CHARS - 1)) ? 5'h0 : msg_pos + 5'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            msg_char <= 8'h0;
        end else begin
            msg_char <= msg_mem[msg_slot][msg_pos];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_keep_lit;
        @(posedge clock) disable iff (!resetn)
        keep_lit |=> !eco_dark_r;
    endproperty
    a_keep_lit: assert property (p_keep_lit) else $error("economy dark during alarm"); // RULE3

    property p_key_wakes;
        @(posedge clock) disable iff (!resetn)
        key_press |=> !eco_dark_r;
    endproperty
    a_key_wakes: assert property (p_key_wakes) else $error("key did not wake backlight"); // RULE2

    property p_dark_needs_timer;
        @(posedge clock) disable iff (!resetn)
        $rose(eco_dark_r) |-> $past(eco_expired) && eco_enabled;
    endproperty
    a_dark_needs_timer: assert property (p_dark_needs_timer) else $error("dark without timeout"); // RULE1

    property p_all_off;
        @(posedge clock) disable iff (!resetn)
        (eco_dark_r && economy_setting == `DEC_ECO_ALL_OFF && !bl_manual_off_r) ##1 $stable(economy_setting)
            |-> !backlight_on;
    endproperty
    a_all_off: assert property (p_all_off) else $error("all-off mode left light on"); // RULE5

    property p_priority;
        @(posedge clock) disable iff (!resetn)
        msg_req[0] |=> msg_slot == 2'h0 && msg_active;
    endproperty
    a_priority: assert property (p_priority) else $error("slot one not shown first"); // RULE10

    property p_guide_toggle;
        @(posedge clock) disable iff (!resetn)
        guide_loaded_r && mode_press && screen_menu |=> guide_visible != $past(guide_visible);
    endproperty
    a_guide_toggle: assert property (p_guide_toggle) else $error("guide did not toggle"); // RULE14

    property p_return;
        @(posedge clock) disable iff (!resetn)
        ret_expired && screen_menu |=> !screen_menu;
    endproperty
    a_return: assert property (p_return) else $error("no auto-return"); // RULE11

    property p_bri_range;
        @(posedge clock) disable iff (!resetn)
        ##1 brightness_level >= `DEC_BRI_MIN && brightness_level <= `DEC_BRI_MAX;
    endproperty
    a_bri_range: assert property (p_bri_range) else $error("brightness out of range"); // RULE15
endmodule // dec_display_ctrl

// >>> dec_panel_model.sv
// Front panel model: keys and contact inputs as wired to the block
`timescale 1ns/1ns
module dec_panel_model (
    // Clock
    input wire logic clock,
    // Panel pins
    output logic key_any_pin,
    output logic mode_key_pin,
    output logic fkey_bl_pin,
    output logic bl_contact_pin,
    output logic [3:0] msg_contact_pin
);
    initial begin
        {key_any_pin, mode_key_pin, fkey_bl_pin, bl_contact_pin} = 4'h0;
        msg_contact_pin = 4'h0;
    end
    // Held four edges so the two-stage synchroniser always sees it
    task automatic press(input int which);
        @(posedge clock);
        #2;
        {bl_contact_pin, fkey_bl_pin, mode_key_pin, key_any_pin} = 4'h1 << which;
        repeat (4) @(posedge clock);
        #2;
        {key_any_pin, mode_key_pin, fkey_bl_pin, bl_contact_pin} = 4'h0;
        repeat (4) @(posedge clock);
        #2;
    endtask
    task automatic contacts(input logic [3:0] v);
        @(posedge clock);
        #2;
        msg_contact_pin = v;
    endtask
endmodule // dec_panel_model

// >>> display_economy_control_tb.sv
// Self-checking testbench of the display economy control block
`timescale 1ns/1ns
module display_economy_control_tb;
    import dec_pkg::*;
    localparam int MSC = 4;
    logic clock = 0;
    logic resetn = 0;
    logic key_any_pin, mode_key_pin, fkey_bl_pin, bl_contact_pin;
    logic [3:0] msg_contact_pin;
    logic alarm_active = 0, power_on_error = 0, hw_error = 0, menu_request = 0;
    logic [1:0] economy_setting = 2'h0;
    logic auto_return_enable = 1, guide_visible_init = 1, bl_key_assigned = 1, bl_contact_assigned = 1;
    logic [2:0] refresh_period_select = 3'h1, overall_brightness = 3'h3;
    logic [3:0] guide_scroll_rate = 4'h1, startup_screen = 4'h9;
    dec_trim_t pv_white_trim = 0, pv_red_trim = 0, setpoint_trim = 0, bargraph_trim = 0, status_led_trim = 0;
    logic msg_wr = 0;
    logic [1:0] msg_wr_slot = 2'h0;
    logic [4:0] msg_wr_index = 5'h0;
    dec_char_t msg_wr_char = 8'h0;
    logic backlight_on, pv_lit, others_lit, msg_active, in_menu, guide_visible, guide_step, refresh_tick;
    logic [7:0] light_percent;
    logic [2:0] brightness_level;
    dec_trim_t pv_white_level, pv_red_level, setpoint_level, bargraph_level, status_led_level;
    logic [1:0] msg_slot;
    dec_char_t msg_char;
    logic [4:0] msg_pos;
    logic [3:0] home_screen;
    int err_count = 0, compares = 0, seed = 36241, n;
    logic [3:0] v;
    int per[5] = '{100, 200, 500, 1000, 2000};

    always #10 clock = ~clock;
    dec_display_ctrl #(.MS_CYCLES(MSC), .ECO_MS(20), .RET_MS(10)) dec_display_ctrl_inst (.*);
    dec_panel_model dec_panel_model_inst (.*);

    ////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask
    task automatic gap(input bit g);
        repeat (2) begin
            n = 0;
            do begin
                cyc(1);
                n++;
            end while ((g ? guide_step : refresh_tick) !== 1'b1 && n < 9000);
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic dec_trim_t tclamp(dec_trim_t t);
        return (t < -4) ? -4 : ((t > 4) ? 4 : t);
    endfunction
    task automatic results();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(2);
        chk(light_percent, 8'h64, "reset light");
        {startup_screen, guide_visible_init} = 5'($random(seed));
        resetn = 1;
        cyc(2);
        chk(8'(home_screen), 8'(startup_screen), "home");
        // Brightness and trims, random with out-of-range values
        repeat (10) begin
            overall_brightness = 3'($random(seed));
            {pv_white_trim, pv_red_trim, setpoint_trim} = 12'($random(seed));
            {bargraph_trim, status_led_trim} = 8'($random(seed));
            cyc(3);
            n = overall_brightness < 1 ? 1 : (overall_brightness > 5 ? 5 : overall_brightness);
            chk(8'(brightness_level), 8'(n), "bri");
            chk(8'(pv_white_level), 8'(tclamp(pv_white_trim)), "pvw");
            chk(8'(pv_red_level), 8'(tclamp(pv_red_trim)), "pvr");
            chk(8'(setpoint_level), 8'(tclamp(setpoint_trim)), "sp");
            chk(8'(bargraph_level), 8'(tclamp(bargraph_trim)), "bar");
            chk(8'(status_led_level), 8'(tclamp(status_led_trim)), "sts");
        end
        // Economy modes, timer restart and wake-up
        for (int e = 0; e < 4; e++) begin
            economy_setting = 2'(e);
            dec_panel_model_inst.press(0);
            cyc(50);
            dec_panel_model_inst.press(0);
            cyc(50);
            chk(8'(others_lit), 8'h01, "restart");
            cyc(60);
            chk(8'(pv_lit), 8'(e != 2), "pv eco");
            if (e == 3) chk(light_percent, 8'h0a, "dim");
            else chk(8'(others_lit), 8'(e == 0), "others eco");
            dec_panel_model_inst.press(0);
            chk(8'(others_lit), 8'h01, "wake");
            chk(light_percent, 8'h64, "wake light");
        end
        // Alarm and error flags keep the light on
        economy_setting = 2'h2;
        for (int f = 0; f < 3; f++) begin
            {alarm_active, power_on_error, hw_error} = 3'h4 >> f;
            dec_panel_model_inst.press(0);
            cyc(110);
            chk(8'(others_lit), 8'h01, "keep lit");
            {alarm_active, power_on_error, hw_error} = 3'h0;
            cyc(110);
            chk(8'(others_lit), 8'h00, "flag gone");
        end
        economy_setting = 2'h0;
        dec_panel_model_inst.press(0);
        // Message slots: preload, then random requests
        for (int s = 0; s < 4; s++) begin
            {msg_wr, msg_wr_slot, msg_wr_index, msg_wr_char} = {1'b1, 2'(s), 5'h0, 8'h41 + 8'(s)};
            cyc(1);
            {msg_wr_index, msg_wr_char} = {5'd20 + 5'(s), 8'h5a};
            cyc(1);
        end
        msg_wr = 0;
        for (int i = 0; i < 12; i++) begin
            v = i == 0 ? 4'hf : (i == 1 ? 4'h8 : 4'($random(seed)));
            dec_panel_model_inst.contacts(v);
            cyc(6);
            n = v[0] ? 0 : (v[1] ? 1 : (v[2] ? 2 : 3));
            chk(8'(msg_active), 8'(|v), "msg on");
            if (|v) chk(8'(msg_slot), 8'(n), "msg prio");
            if (|v && msg_pos === 5'h0) chk(msg_char, 8'h41 + 8'(n), "msg char");
        end
        dec_panel_model_inst.contacts(4'h0);
        // Manual backlight toggle, every pairing of assigned sources
        n = 0;
        for (int a = 0; a < 4; a++) begin
            {bl_key_assigned, bl_contact_assigned} = 2'(a);
            dec_panel_model_inst.press(3);
            n ^= a & 1;
            chk(8'(backlight_on), 8'(n == 0), "contact");
            dec_panel_model_inst.press(2);
            n ^= a / 2;
            chk(8'(backlight_on), 8'(n == 0), "fkey");
        end
        // Guide toggle and auto-return
        dec_panel_model_inst.press(1);
        chk(8'(guide_visible), 8'(guide_visible_init), "guide outside");
        menu_request = 1;
        cyc(4);
        dec_panel_model_inst.press(1);
        chk(8'(in_menu), 8'h01, "menu");
        chk(8'(guide_visible), 8'(!guide_visible_init), "guide toggle");
        cyc(60);
        chk(8'(in_menu), 8'h00, "return");
        {auto_return_enable, menu_request} = 2'h0;
        cyc(4);
        menu_request = 1;
        cyc(80);
        chk(8'(in_menu), 8'h01, "no return");
        // Refresh period per setting, then guide scroll step for a random rate
        for (int s = 1; s < 6; s++) begin
            refresh_period_select = 3'(s);
            gap(0);
            chk(8'(n / MSC / 10), 8'(per[s - 1] / 10), "period");
            chk(8'(n % (MSC * 10)), 8'h00, "period exact");
        end
        guide_scroll_rate = 4'($random(seed));
        v = guide_scroll_rate < 1 ? 1 : (guide_scroll_rate > 8 ? 8 : guide_scroll_rate);
        gap(1);
        chk(8'(n / MSC / 10), 8'(90 - 10 * v), "scroll");
        chk(8'(n % (MSC * 10)), 8'h00, "scroll exact");
        results();
    end

    initial begin
        repeat (90000) @(posedge clock);
        err_count++;
        results();
    end
endmodule // display_economy_control_tb
